// ---- hdl/ebawc_ctrl.sv ----
// external bus area wait controller: register file, area decode and bus cycle sequencer
// Notes on behaviour
// - eight external areas, 128 kbyte or 2 Mbyte
// - address strobe active while address valid
// - read strobe active in each external read
// - write strobe active while write data driven, except in the first state (T1)
// - wait pin honoured only in three-state areas
// - per-area bit picks two or three states
// - on-chip accesses use fixed state count
// - single-chip modes ignore length and enable settings
// - reset, hardware standby load; software standby keeps
// - wait register bits 7..4 read one
// - mode field selects programmable, none, pin modes
// - count field gives zero to three waits
// - per-area enable off selects pin wait 0
// - length bit, then enable, then mode field
// - two-state areas never extended by waits
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
module ebawc_ctrl
   import ebawc_pkg::*;
(
   input  wire logic        clk_i,          // system clock, 40 MHz
   input  wire logic        rst_i,          // synchronous reset, active high
   input  wire logic        hw_standby_i,   // hardware standby, reloads registers
   input  wire logic        sw_standby_i,   // software standby, registers kept
   input  wire logic [2:0]  mode_i,         // chip operating mode
   // classic wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [17:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // access request from the cpu side
   input  wire logic        req_i,          // start access, taken when idle
   input  wire logic        req_we_i,       // 1 write, 0 read
   input  wire logic        req_onchip_i,   // target is on-chip memory or register
   input  wire logic [23:0] req_addr_i,
   input  wire logic [7:0]  req_wdata_i,
   output logic             busy_o,         // access in progress
   output logic             done_o,         // one-cycle pulse at end of access
   output logic      [7:0]  rdata_o,        // read data of last external read
   // external bus
   output logic      [23:0] ext_addr_o,
   output logic      [7:0]  ext_data_o,
   output logic             ext_data_oe_o,
   input  wire logic [7:0]  ext_data_i,
   output logic             address_valid_strobe_n_o,
   output logic             read_strobe_n_o,
   output logic             write_strobe_n_o,
   input  wire logic        wait_req_n_i,   // wait request, active low
   output logic      [2:0]  upper_addr_en_n_o // upper address lines enable, active low
);

   // whole state of the block
   typedef struct packed {
      logic [7:0]   len;      // area_access_length_select
      logic [3:0]   wait_lo;  // wait_mode_and_count bits 3..0
      logic [7:0]   wen;      // area_wait_unit_enable
      logic [3:0]   uadr;     // upper address bits 7..5 and bit 0
      logic         ack;
      logic [31:0]  dat;
      ebawc_st_type st;
      ebawc_ew_type ew;       // wait handling latched at request
      logic         three;    // three-state access
      logic [1:0]   cnt;      // wait or internal state count
      logic [23:0]  addr;
      logic [7:0]   wdata;
      logic         we;
      logic [7:0]   rdata;
      logic         done;
      logic         as_n;
      logic         rd_n;
      logic         wr_n;
      logic         oe;
   } ebawc_state_type;

   ebawc_state_type cur_ff;   // registered state
   ebawc_state_type nxt_ff;   // next state

   // area number of an address in the current address mode
   function automatic logic [2:0] area_of(input logic [23:0] a, input logic wide);
      area_of = wide ? a[EBAWC_AREA_LSB_16M +: 3] : a[EBAWC_AREA_LSB_1M +: 3];
   endfunction

   // wait handling of an area: length bit first, then enable, then mode field
   function automatic ebawc_ew_type ew_of(input logic lbit, input logic ebit,
                                           input logic [1:0] wms);
      if (!lbit)
         ew_of = EBAWC_EW_NONE;
      else if (!ebit)
         ew_of = EBAWC_EW_PIN0;
      else
      begin
         case (wms)
            EBAWC_WMS_PROG: ew_of = EBAWC_EW_PROG;
            EBAWC_WMS_NONE: ew_of = EBAWC_EW_NONE;
            EBAWC_WMS_PIN1: ew_of = EBAWC_EW_PIN1;
            default:        ew_of = EBAWC_EW_AUTO;
         endcase
      end
   endfunction

   // register decode of a bus byte address
   function automatic logic [1:0] reg_of(input logic [17:0] a, output logic hit);
      hit    = (a[1:0] == 2'h0);
      reg_of = 2'h0;
      if (a[17:2] == EBAWC_IDX_LEN)       reg_of = 2'h0;
      else if (a[17:2] == EBAWC_IDX_WAIT) reg_of = 2'h1;
      else if (a[17:2] == EBAWC_IDX_WEN)  reg_of = 2'h2;
      else if (a[17:2] == EBAWC_IDX_UADR) reg_of = 2'h3;
      else                                hit = 1'b0;
   endfunction

   logic       sc_mode;     // single-chip mode
   logic       wide_mode;   // 16-Mbyte address mode
   logic       bus_req;     // new bus cycle toward the slave
   logic       reg_hit;     // address maps to a register
   logic [1:0] reg_sel;     // which register
   logic [2:0] req_area;    // area of the incoming access
   logic       wait_on;     // wait pin asserted
   logic       pin_mode;    // latched handling follows the pin

   assign sc_mode   = (mode_i == EBAWC_MODE_SC6) || (mode_i == EBAWC_MODE_SC7);
   assign wide_mode = (mode_i == EBAWC_MODE_16M);
   assign bus_req   = cyc_i && stb_i && !cur_ff.ack;
   // register decode; the function hands back the hit flag through its output argument
   always_comb
   begin
      reg_sel = reg_of(adr_i, reg_hit);
   end
   assign req_area  = area_of(req_addr_i, wide_mode);
   assign wait_on   = !wait_req_n_i;
   assign pin_mode  = (cur_ff.ew == EBAWC_EW_PIN0) || (cur_ff.ew == EBAWC_EW_PIN1);

   // next-state logic: register file, then bus cycle sequencer
   always_comb
   begin
      nxt_ff      = cur_ff;
      nxt_ff.done = 1'b0;
      // wishbone: answer one cycle after the request, drop ack the cycle after
      nxt_ff.ack  = bus_req;
      if (bus_req)
      begin
         nxt_ff.dat = 32'h0;                             // unmapped reads zero
         if (reg_hit)
         begin
            case (reg_sel)
               2'h0:    nxt_ff.dat[7:0] = cur_ff.len;
               2'h1:    nxt_ff.dat[7:0] = {EBAWC_WAIT_HI, cur_ff.wait_lo};
               2'h2:    nxt_ff.dat[7:0] = cur_ff.wen;
               default: nxt_ff.dat[7:0] = {cur_ff.uadr[3:1], EBAWC_UADR_MID,
                                           cur_ff.uadr[0]};
            endcase
         end
         if (we_i && sel_i[0] && reg_hit)
         begin
            case (reg_sel)
               2'h0:    nxt_ff.len     = dat_i[7:0];
               2'h1:    nxt_ff.wait_lo = dat_i[3:0];
               2'h2:    nxt_ff.wen     = dat_i[7:0];
               default:
               begin
                  // upper address enables change only in 16-Mbyte mode
                  if (wide_mode)
                     nxt_ff.uadr[3:1] = dat_i[7:5];
                  nxt_ff.uadr[0] = dat_i[0];
               end
            endcase
         end
      end
      // bus cycle sequencer
      case (cur_ff.st)
         EBAWC_ST_IDLE:
         begin
            if (req_i)
            begin
               nxt_ff.addr  = req_addr_i;
               nxt_ff.wdata = req_wdata_i;
               nxt_ff.we    = req_we_i;
               if (req_onchip_i || sc_mode)
               begin
                  // fixed length, settings ignored
                  nxt_ff.st  = EBAWC_ST_INT;
                  nxt_ff.cnt = EBAWC_INT_STATES - 2'h1;
               end
               else
               begin
                  nxt_ff.st    = EBAWC_ST_T1;
                  nxt_ff.three = cur_ff.len[req_area];
                  nxt_ff.ew    = ew_of(cur_ff.len[req_area], cur_ff.wen[req_area],
                                       cur_ff.wait_lo[EBAWC_WMS_LSB +: 2]);
               end
            end
         end
         EBAWC_ST_INT:
         begin
            if (cur_ff.cnt <= 2'h1)
            begin
               nxt_ff.st   = EBAWC_ST_IDLE;
               nxt_ff.done = 1'b1;
            end
            else
               nxt_ff.cnt = cur_ff.cnt - 2'h1;
         end
         EBAWC_ST_T1:
            nxt_ff.st = EBAWC_ST_T2;
         EBAWC_ST_T2:
         begin
            nxt_ff.cnt = cur_ff.wait_lo[EBAWC_WC_LSB +: 2];
            if (!cur_ff.three)
            begin
               // two-state area ends here, pin and count ignored
               nxt_ff.st   = EBAWC_ST_IDLE;
               nxt_ff.done = 1'b1;
               nxt_ff.rdata = cur_ff.we ? cur_ff.rdata : ext_data_i;
            end
            else
            begin
               nxt_ff.st = EBAWC_ST_T3;
               case (cur_ff.ew)
                  EBAWC_EW_PROG:
                     if (cur_ff.wait_lo[EBAWC_WC_LSB +: 2] != 2'h0)
                        nxt_ff.st = EBAWC_ST_TW;
                  EBAWC_EW_PIN0:
                  begin
                     nxt_ff.cnt = 2'h0;
                     if (wait_on)
                        nxt_ff.st = EBAWC_ST_TW;
                  end
                  EBAWC_EW_PIN1:
                     if (wait_on || cur_ff.wait_lo[EBAWC_WC_LSB +: 2] != 2'h0)
                        nxt_ff.st = EBAWC_ST_TW;
                  EBAWC_EW_AUTO:
                     if (wait_on && cur_ff.wait_lo[EBAWC_WC_LSB +: 2] != 2'h0)
                        nxt_ff.st = EBAWC_ST_TW;
                  default:
                     nxt_ff.st = EBAWC_ST_T3;
               endcase
            end
         end
         EBAWC_ST_TW:
         begin
            if (cur_ff.cnt > 2'h1)
               nxt_ff.cnt = cur_ff.cnt - 2'h1;
            else if (pin_mode && wait_on)
               nxt_ff.cnt = 2'h0;
            else
               nxt_ff.st = EBAWC_ST_T3;
         end
         EBAWC_ST_T3:
         begin
            nxt_ff.st    = EBAWC_ST_IDLE;
            nxt_ff.done  = 1'b1;
            nxt_ff.rdata = cur_ff.we ? cur_ff.rdata : ext_data_i;
         end
         default:
            nxt_ff.st = EBAWC_ST_IDLE;
      endcase
      // strobes follow the next state of an external cycle
      nxt_ff.as_n = 1'b1;
      nxt_ff.rd_n = 1'b1;
      nxt_ff.wr_n = 1'b1;
      nxt_ff.oe   = 1'b0;
      if (nxt_ff.st inside {EBAWC_ST_T1, EBAWC_ST_T2, EBAWC_ST_TW, EBAWC_ST_T3})
      begin
         nxt_ff.as_n = 1'b0;
         nxt_ff.rd_n = nxt_ff.we;
         nxt_ff.oe   = nxt_ff.we;
         nxt_ff.wr_n = !(nxt_ff.we && nxt_ff.st != EBAWC_ST_T1);
      end
   end

   // state register; reset and hardware standby reload, software standby holds
   always_ff @(posedge clk_i)
   begin
      if (rst_i || hw_standby_i)
      begin
         cur_ff         <= '0;
         cur_ff.len     <= EBAWC_RST_LEN;
         cur_ff.wait_lo <= EBAWC_RST_WAIT[3:0];
         cur_ff.wen     <= EBAWC_RST_WEN;
         cur_ff.uadr    <= {EBAWC_RST_UADR[7:5], EBAWC_RST_UADR[0]};
         cur_ff.st      <= EBAWC_ST_IDLE;
         cur_ff.ew      <= EBAWC_EW_NONE;
         cur_ff.as_n    <= 1'b1;
         cur_ff.rd_n    <= 1'b1;
         cur_ff.wr_n    <= 1'b1;
      end
      else
         cur_ff <= nxt_ff;
   end

   // outputs
   assign dat_o                    = cur_ff.dat;
   assign ack_o                    = cur_ff.ack;
   assign busy_o                   = (cur_ff.st != EBAWC_ST_IDLE);
   assign done_o                   = cur_ff.done;
   assign rdata_o                  = cur_ff.rdata;
   assign ext_addr_o               = cur_ff.addr;
   assign ext_data_o               = cur_ff.wdata;
   assign ext_data_oe_o            = cur_ff.oe;
   assign address_valid_strobe_n_o = cur_ff.as_n;
   assign read_strobe_n_o          = cur_ff.rd_n;
   assign write_strobe_n_o         = cur_ff.wr_n;
   assign upper_addr_en_n_o        = cur_ff.uadr[3:1];

   // checks
   sequence s_two_state;
      cur_ff.st == EBAWC_ST_T2 && !cur_ff.three;
   endsequence

   sequence s_prog_entry;
      cur_ff.st == EBAWC_ST_T2 && cur_ff.three && cur_ff.ew == EBAWC_EW_PROG;
   endsequence

   chk_strobe_addr: assert property (@(posedge clk_i) disable iff (rst_i)
      busy_o && cur_ff.st != EBAWC_ST_INT |-> !address_valid_strobe_n_o)
      else $error("address strobe idle during external cycle");

   chk_read_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
      !read_strobe_n_o |-> !cur_ff.we && !address_valid_strobe_n_o)
      else $error("read strobe outside external read");

   chk_write_data: assert property (@(posedge clk_i) disable iff (rst_i)
      !write_strobe_n_o |-> ext_data_oe_o && cur_ff.we && ext_data_o == cur_ff.wdata)
      else $error("write strobe without driven data");

   chk_two_state: assert property (@(posedge clk_i) disable iff (rst_i || hw_standby_i)
      s_two_state |=> done_o && !busy_o)
      else $error("two-state access extended");

   chk_prog_count: assert property (@(posedge clk_i) disable iff (rst_i || hw_standby_i)
      s_prog_entry and cur_ff.wait_lo[1:0] == 2'h2 |=> cur_ff.st == EBAWC_ST_TW
      ##1 cur_ff.st == EBAWC_ST_TW ##1 cur_ff.st == EBAWC_ST_T3)
      else $error("programmable wait count wrong");

   chk_int_fixed: assert property (@(posedge clk_i) disable iff (rst_i || hw_standby_i)
      cur_ff.st == EBAWC_ST_IDLE && req_i && (req_onchip_i || sc_mode)
      |=> address_valid_strobe_n_o ##1 done_o)
      else $error("on-chip access length not fixed");

   chk_reset_vals: assert property (@(posedge clk_i)
      $past(rst_i || hw_standby_i) |->
      cur_ff.len == 8'hff && cur_ff.wen == 8'hff && cur_ff.wait_lo == 4'h3)
      else $error("register reset value wrong");

   chk_wait_read: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o && $past(reg_hit && reg_sel == 2'h1) |-> dat_o[7:4] == 4'hf)
      else $error("wait register high bits not one");

   chk_pin0_hold: assert property (@(posedge clk_i) disable iff (rst_i || hw_standby_i)
      cur_ff.st == EBAWC_ST_TW && cur_ff.ew == EBAWC_EW_PIN0 && wait_on |=> cur_ff.st == EBAWC_ST_TW)
      else $error("pin wait mode 0 ignored wait pin");

endmodule

// ---- hdl/ebawc_pkg.sv ----
// package: register map, reset values, encodings and states of the area wait controller
package ebawc_pkg;
   // register indices as printed; byte address on the bus is four times the index
   localparam logic [15:0] EBAWC_IDX_LEN   = 16'hffed; // area_access_length_select
   localparam logic [15:0] EBAWC_IDX_WAIT  = 16'hffee; // wait_mode_and_count
   localparam logic [15:0] EBAWC_IDX_WEN   = 16'hffef; // area_wait_unit_enable
   localparam logic [15:0] EBAWC_IDX_UADR  = 16'hfff3; // upper_address_line_enable
   // values after reset or hardware standby
   localparam logic [7:0]  EBAWC_RST_LEN   = 8'hff;
   localparam logic [7:0]  EBAWC_RST_WAIT  = 8'hf3;
   localparam logic [7:0]  EBAWC_RST_WEN   = 8'hff;
   localparam logic [7:0]  EBAWC_RST_UADR  = 8'hfe;
   // fixed parts of the registers
   localparam logic [3:0]  EBAWC_WAIT_HI   = 4'hf;     // wait register bits 7..4
   localparam logic [3:0]  EBAWC_UADR_MID  = 4'hf;     // upper address register bits 4..1
   // field positions in the wait register
   localparam int          EBAWC_WMS_LSB   = 2;        // wait_mode_select_field lsb
   localparam int          EBAWC_WC_LSB    = 0;        // wait_count_field lsb
   // area number position in each address mode
   localparam int          EBAWC_AREA_LSB_1M  = 17;    // 128-kbyte areas
   localparam int          EBAWC_AREA_LSB_16M = 21;    // 2-Mbyte areas
   // operating modes of the chip
   localparam logic [2:0]  EBAWC_MODE_16M  = 3'h3;     // 16-Mbyte expanded mode
   localparam logic [2:0]  EBAWC_MODE_SC6  = 3'h6;     // single-chip mode
   localparam logic [2:0]  EBAWC_MODE_SC7  = 3'h7;     // single-chip mode
   // fixed access length of on-chip targets, in states
   localparam logic [1:0]  EBAWC_INT_STATES = 2'h2;
   // wait_mode_select_field encodings
   localparam logic [1:0]  EBAWC_WMS_PROG  = 2'h0;     // programmable wait
   localparam logic [1:0]  EBAWC_WMS_NONE  = 2'h1;     // no controller waits
   localparam logic [1:0]  EBAWC_WMS_PIN1  = 2'h2;     // pin wait mode 1
   localparam logic [1:0]  EBAWC_WMS_AUTO  = 2'h3;     // pin auto-wait
   // effective wait handling of one access
   typedef enum logic [2:0] {
      EBAWC_EW_NONE = 3'b000,
      EBAWC_EW_PIN0 = 3'b001,
      EBAWC_EW_PROG = 3'b010,
      EBAWC_EW_PIN1 = 3'b011,
      EBAWC_EW_AUTO = 3'b100
   } ebawc_ew_type;
   // bus cycle states
   typedef enum logic [2:0] {
      EBAWC_ST_IDLE = 3'b000,
      EBAWC_ST_T1   = 3'b001,
      EBAWC_ST_T2   = 3'b010,
      EBAWC_ST_TW   = 3'b011,
      EBAWC_ST_T3   = 3'b100,
      EBAWC_ST_INT  = 3'b101
   } ebawc_st_type;
endpackage

// ---- sim/ebawc_mem_model.sv ----
// external byte memory with a wait request pin, far side of the area wait controller
`timescale 1ns/1ps
module ebawc_mem_model
(
   input  wire logic        clk_i,
   input  wire logic [23:0] ext_addr_i,
   input  wire logic [7:0]  ext_data_i,
   input  wire logic        ext_data_oe_i,
   input  wire logic        address_valid_strobe_n_i,
   input  wire logic        read_strobe_n_i,
   input  wire logic        write_strobe_n_i,
   input  wire logic [1:0]  wait_len_i,   // cycles of wait request per access
   output logic      [7:0]  ext_data_o,
   output logic             wait_req_n_o
);
   logic [7:0] mem_ff [256];  // byte storage
   logic [7:0] last_ff;       // last byte driven
   logic       as_d_ff;       // strobe one cycle back
   logic [1:0] cnt_ff;        // wait cycles left
   // empty memory, wait pin idle
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem_ff[i] = 8'h00;
      last_ff = 8'h00;
      as_d_ff = 1'b1;
      cnt_ff = 2'h0;
      wait_req_n_o = 1'b1;
   end
   // released bus shows the inverse of the last byte
   assign ext_data_o = !read_strobe_n_i ? mem_ff[ext_addr_i[7:0]] : ~last_ff;
   // wait pin low from second state for the asked number of cycles
   always @(posedge clk_i)
   begin
      as_d_ff <= address_valid_strobe_n_i;
      if (!read_strobe_n_i)
         last_ff <= mem_ff[ext_addr_i[7:0]];
      if (!write_strobe_n_i && ext_data_oe_i)
         mem_ff[ext_addr_i[7:0]] <= ext_data_i;
      if (as_d_ff && !address_valid_strobe_n_i)
      begin
         cnt_ff <= wait_len_i;
         wait_req_n_o <= (wait_len_i == 2'h0);
      end
      else if (cnt_ff != 2'h0)
      begin
         cnt_ff <= cnt_ff - 2'h1;
         wait_req_n_o <= (cnt_ff <= 2'h1);
      end
      else
         wait_req_n_o <= 1'b1;
   end
endmodule

// ---- sim/external_bus_area_wait_control_tb_top.sv ----
// self-checking bench: registers, standby, area decode, access lengths and wait modes
`timescale 1ns/1ps
module external_bus_area_wait_control_tb_top;
   import ebawc_pkg::*;
   localparam logic [17:0] A_LEN  = 18'h3ffb4;
   localparam logic [17:0] A_WAIT = 18'h3ffb8;
   localparam logic [17:0] A_WEN  = 18'h3ffbc;
   localparam logic [17:0] A_UADR = 18'h3ffcc;
   localparam logic [17:0] A_NONE = 18'h3ffc0;   // unmapped
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        hw_standby_i = 1'b0;
   logic        sw_standby_i = 1'b0;
   logic [2:0]  mode_i = 3'h1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [17:0] adr_i = 18'h0;
   logic [3:0]  sel_i = 4'h1;
   logic [31:0] dat_i = 32'h0;
   logic        req_i = 1'b0;
   logic        req_we_i = 1'b0;
   logic        req_onchip_i = 1'b0;
   logic [23:0] req_addr_i = 24'h0;
   logic [7:0]  req_wdata_i = 8'h0;
   logic [1:0]  wait_len = 2'h0;
   logic [31:0] dat_o;
   logic        ack_o, busy_o, done_o, ext_data_oe_o, as_n, rd_n, wr_n, wait_n;
   logic [7:0]  rdata_o, ext_data_o, ext_data_i;
   logic [23:0] ext_addr_o;
   logic [2:0]  uadr_n;
   logic [7:0]  len_s, wcr_s, wen_s;   // register shadows
   logic [7:0]  shadow [256];          // memory shadow
   logic [2:0]  mtab [5] = '{3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
   int          failures = 0;
   int          n_compared = 0;
   int          cycles = 0;
   int          seed = 73275;
   ebawc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .hw_standby_i(hw_standby_i),
      .sw_standby_i(sw_standby_i), .mode_i(mode_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .req_i(req_i), .req_we_i(req_we_i), .req_onchip_i(req_onchip_i),
      .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .busy_o(busy_o),
      .done_o(done_o), .rdata_o(rdata_o), .ext_addr_o(ext_addr_o),
      .ext_data_o(ext_data_o), .ext_data_oe_o(ext_data_oe_o), .ext_data_i(ext_data_i),
      .address_valid_strobe_n_o(as_n), .read_strobe_n_o(rd_n),
      .write_strobe_n_o(wr_n), .wait_req_n_i(wait_n), .upper_addr_en_n_o(uadr_n));
   ebawc_mem_model mem (.clk_i(clk_i), .ext_addr_i(ext_addr_o), .ext_data_i(ext_data_o),
      .ext_data_oe_i(ext_data_oe_o), .address_valid_strobe_n_i(as_n),
      .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .wait_len_i(wait_len),
      .ext_data_o(ext_data_i), .wait_req_n_o(wait_n));
   // clock, 25 ns period
   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end
   // hang guard
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         failures++;
         end_of_test();
      end
   end
   // counts, verdict, stop
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // one comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // classic single wishbone cycle
   task automatic wb(input logic w, input logic [17:0] a, input logic [7:0] d,
                     output logic [7:0] q);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      // wait for the answer however long it takes; only the hang guard ends a wait
      do
      begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      q = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   // read and compare
   task automatic rdchk(input logic [17:0] a, input logic [7:0] e);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask
   // write then read back
   task automatic wrchk(input logic [17:0] a, input logic [7:0] d, input logic [7:0] e);
      logic [7:0] q;
      wb(1'b1, a, d, q);
      rdchk(a, e);
   endtask
   // load all three wait registers and their shadows
   task automatic cfg(input logic [7:0] l, input logic [7:0] w, input logic [7:0] e);
      wrchk(A_LEN, l, l);
      wrchk(A_WAIT, w, {4'hf, w[3:0]});
      wrchk(A_WEN, e, e);
      len_s = l;
      wcr_s = {4'hf, w[3:0]};
      wen_s = e;
   endtask
   // expected cycles from accept to done
   function automatic int exp_n(input logic [2:0] m, input logic onc,
                                input logic [23:0] a, input int wl);
      logic [2:0] ar;
      int         wc;
      ar = (m == EBAWC_MODE_16M) ? a[23:21] : a[19:17];
      wc = wcr_s[1:0];
      if (onc || m == EBAWC_MODE_SC6 || m == EBAWC_MODE_SC7)
         return 2;
      if (!len_s[ar])
         return 3;
      if (!wen_s[ar])
         return 4 + wl;
      case (wcr_s[3:2])
         2'h0:    return 4 + wc;
         2'h1:    return 4;
         2'h2:    return 4 + ((wl > wc) ? wl : wc);
         default: return 4 + ((wl > 0) ? wc : 0);
      endcase
   endfunction
   // one access with strobe watch
   task automatic acc(input logic w, input logic onc, input logic [23:0] a,
                      input logic [7:0] d, input int wl);
      int   n, nas, nrd, nwr, bad, en;
      logic ext;
      ext = !onc && mode_i != EBAWC_MODE_SC6 && mode_i != EBAWC_MODE_SC7;
      en = exp_n(mode_i, onc, a, wl);
      n = 0;
      nas = 0;
      nrd = 0;
      nwr = 0;
      bad = 0;
      @(posedge clk_i);
      wait_len <= wl[1:0];
      req_i <= 1'b1;
      req_we_i <= w;
      req_onchip_i <= onc;
      req_addr_i <= a;
      req_wdata_i <= d;
      @(posedge clk_i);
      req_i <= 1'b0;
      do
      begin
         @(posedge clk_i);
         n++;
         if (as_n === 1'b0)
            nas++;
         if (rd_n === 1'b0)
            nrd++;
         if (wr_n === 1'b0)
         begin
            nwr++;
            if (ext_data_o !== d || ext_data_oe_o !== 1'b1)
               bad++;
         end
      end while (done_o !== 1'b1 && n < 40);
      chk(n, en);
      chk(nas != 0, ext);
      chk(nrd != 0, ext && !w);
      chk(nwr != 0, ext && w);
      chk(bad, 0);
      if (ext && w)
         shadow[a[7:0]] = d;
      if (ext && !w)
         chk(rdata_o, shadow[a[7:0]]);
   endtask
   // main sequence
   initial
   begin
      logic [31:0] r, r2;
      for (int i = 0; i < 256; i++)
         shadow[i] = 8'h00;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(A_LEN, 8'hff);
      rdchk(A_WAIT, 8'hf3);
      rdchk(A_WEN, 8'hff);
      rdchk(A_UADR, 8'hfe);
      rdchk(A_NONE, 8'h00);
      chk(uadr_n, 3'h7);
      // write with byte lane 0 off must be ignored
      sel_i <= 4'h0;
      wrchk(A_LEN, 8'h00, 8'hff);
      sel_i <= 4'h1;
      $display("reset values test done");
      sw_standby_i <= 1'b1;
      wrchk(A_WAIT, 8'h00, 8'hf0);
      wrchk(A_LEN, 8'h5a, 8'h5a);
      wrchk(A_WEN, 8'h3c, 8'h3c);
      sw_standby_i <= 1'b0;
      rdchk(A_LEN, 8'h5a);
      @(posedge clk_i);
      hw_standby_i <= 1'b1;
      @(posedge clk_i);
      hw_standby_i <= 1'b0;
      rdchk(A_LEN, 8'hff);
      rdchk(A_WAIT, 8'hf3);
      rdchk(A_WEN, 8'hff);
      // upper address enables locked outside 16-Mbyte mode, writable in it
      wrchk(A_UADR, 8'h00, 8'hfe);
      chk(uadr_n, 3'h7);
      mode_i <= EBAWC_MODE_16M;
      wrchk(A_UADR, 8'h1e, 8'h1e);
      chk(uadr_n, 3'h0);
      wrchk(A_UADR, 8'hfe, 8'hfe);
      chk(uadr_n, 3'h7);
      mode_i <= 3'h1;
      $display("standby test done");
      for (int k = 0; k < 32; k++)
      begin
         cfg(8'h01, {4'h0, k[3:0]}, {7'h0, k[4]});
         acc(k[0], 1'b0, 24'h000010 + k, k[7:0], 2);
         acc(k[1], 1'b0, 24'h000020 + k, ~k[7:0], 0);
         acc(1'b0, 1'b0, 24'h020030, 8'h00, 3);
      end
      $display("wait mode table done");
      for (int i = 0; i < 60; i++)
      begin
         r = $random(seed);
         mode_i <= mtab[r[31:29] % 5];
         cfg(r[7:0], r[15:8], r[23:16]);
         repeat (4)
         begin
            r = $random(seed);
            r2 = $random(seed);
            acc(r[0], r[3:1] == 3'h0, r2[23:0], r[15:8], r[5:4]);
         end
      end
      $display("random access test done");
      end_of_test();
   end
endmodule
